// file: fbp_defs.vh
// flash block protection unit: offsets, fields, reset values, keys
// assumes a 32-bit AHB-Lite register window and byte addressing
`ifndef FBP_DEFS_VH
`define FBP_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FBP_OFS_ADDR 12'h000
`define FBP_OFS_DATA 12'h004
`define FBP_OFS_CTRL 12'h008
`define FBP_OFS_RIS 12'h00C
`define FBP_OFS_IM 12'h010
`define FBP_OFS_MISC 12'h014
`define FBP_OFS_RDEN 12'h130
`define FBP_OFS_PGEN 12'h134
`define FBP_OFS_DBGW 12'h1D0
`define FBP_OFS_FLT 12'h1F0

// ----------------------------------------
// control register fields and key
// ----------------------------------------
`define FBP_KEY 16'hA442
`define FBP_CTRL_WRITE 0
`define FBP_CTRL_ERASE 1
`define FBP_CTRL_MERASE 2
`define FBP_CTRL_COMMIT 3

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define FBP_IRQ_ACCESS 0
`define FBP_IRQ_PROG 1

// ----------------------------------------
// commit selectors, reset values, debug bits
// ----------------------------------------
`define FBP_SEL_RDEN 32'h00000000
`define FBP_SEL_PGEN 32'h00000001
`define FBP_SEL_DBGW 32'h75100000
`define FBP_PROT_RESET 32'hFFFFFFFF
`define FBP_DBGW_RESET 32'hFFFFFFFE
`define FBP_DBG_LO 0
`define FBP_DBG_HI 1
`define FBP_BLOCK_SHIFT 11

`endif

// file: fbp_unit.v
// flash block protection unit: per-block access gate, commit, interrupts
// assumes one AHB-Lite master, flash array answering with a done pulse
//
// Notes on behaviour
// - two enable bits per 2-KB block
// - program-enable one permits program and erase
// - read-enable zero allows fetch, refuses data
// - both zero: execute only
// - program one, read zero: no data reads
// - program zero, read one: read only
// - both one: no protection at all
// - protected read gets a bus fault
// - protected program refused, irq if masked in
// - factory state all enable bits one
// - bits only clear; uncommitted revert on power-on
// - commit through control register makes permanent
// - data-bus constant loads blocked on execute-only
// - read-enable zero blocks debugger reads too
// - two debug bits in user debug word
// - debug disabled blocks debug port access
// - disabled debug cannot be re-enabled
// - completion sets programming-complete status
// - protected program attempt sets violation status
// - raw visible; masked gates interrupt
// - write one clears raw and masked
`timescale 1ns/100ps
`default_nettype none
`include "fbp_defs.vh"

module fbp_unit #(
    parameter ADDR_W = 16
) (
    // clock and reset
    input wire clk,
    input wire srst,
    input wire por,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // flash read requests from core and debugger
    input wire rd_req,
    input wire rd_fetch,
    input wire rd_debug,
    input wire [ADDR_W-1:0] rd_addr,
    output wire rd_allow,
    output wire rd_fault,
    // flash array program/erase port
    output reg fl_start_q,
    output reg [2:0] fl_op_q,
    output reg [31:0] fl_addr_q,
    output reg [31:0] fl_data_q,
    input wire fl_done,
    // debug gate
    input wire dbg_req,
    output wire dbg_allow,
    output wire dbg_enabled,
    // interrupt
    output wire irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [31:0] addr_q;
    reg [31:0] data_q;
    reg [3:0] busy_q;
    reg [1:0] ris_q;
    reg [1:0] im_q;
    reg [31:0] rden_q;
    reg [31:0] pgen_q;
    reg [31:0] rden_nv_q;
    reg [31:0] pgen_nv_q;
    reg [31:0] dbgw_q;
    reg [31:0] dbgw_nv_q;
    reg dbg_en_q;
    reg por_done_q;
    reg [1:0] flt_q;
    reg wr_ph_q;
    reg rd_ph_q;
    reg [11:0] ofs_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire take = hsel & hready & htrans[1];
    wire wr = wr_ph_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire key_ok = (hwdata[31:16] == `FBP_KEY);
    wire ctrl_wr = wr & (ofs_q == `FBP_OFS_CTRL) & key_ok & (busy_q == 4'h0);
    wire [4:0] blk = addr_q[`FBP_BLOCK_SHIFT+4:`FBP_BLOCK_SHIFT];
    wire pg_ok = pgen_q[blk];
    wire pg_cmd = ctrl_wr & (hwdata[`FBP_CTRL_WRITE] | hwdata[`FBP_CTRL_ERASE]);
    wire me_cmd = ctrl_wr & hwdata[`FBP_CTRL_MERASE];
    wire me_ok = &pgen_q;
    wire cm_cmd = ctrl_wr & hwdata[`FBP_CTRL_COMMIT];
    wire deny = (pg_cmd & ~pg_ok) | (me_cmd & ~me_ok);
    wire go = (pg_cmd & pg_ok) | (me_cmd & me_ok);

    // ----------------------------------------
    // read gate
    // ----------------------------------------
    wire [4:0] rblk = rd_addr[`FBP_BLOCK_SHIFT+4:`FBP_BLOCK_SHIFT];
    wire rd_ok = rd_fetch & ~rd_debug | rden_q[rblk];
    assign rd_allow = rd_req & rd_ok & (~rd_debug | dbg_en_q);
    assign rd_fault = rd_req & ~rd_allow;
    assign dbg_allow = dbg_req & dbg_en_q;
    assign dbg_enabled = dbg_en_q;
    assign irq = |(ris_q & im_q);

    // ----------------------------------------
    // address phase capture
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (srst)
        begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            ofs_q <= 12'h000;
        end
        else
        begin
            wr_ph_q <= take & hwrite;
            rd_ph_q <= take & ~hwrite;
            if (take)
                ofs_q <= haddr[11:0];
        end
    end

    // ----------------------------------------
    // control, interrupt, volatile registers
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (srst)
        begin
            addr_q <= 32'h00000000;
            data_q <= 32'h00000000;
            busy_q <= 4'h0;
            ris_q <= 2'h0;
            im_q <= 2'h0;
            fl_start_q <= 1'b0;
            fl_op_q <= 3'h0;
            fl_addr_q <= 32'h00000000;
            fl_data_q <= 32'h00000000;
            flt_q <= 2'h0;
        end
        else
        begin
            fl_start_q <= go;
            if (go)
            begin
                fl_op_q <= hwdata[2:0];
                fl_addr_q <= addr_q;
                fl_data_q <= data_q;
                busy_q <= {1'b0, hwdata[2:0]};
            end
            else if (cm_cmd)
                busy_q <= 4'h8;
            else if (fl_done || busy_q[3])
                busy_q <= 4'h0;
            if (wr && ofs_q == `FBP_OFS_ADDR)
                addr_q <= hwdata;
            if (wr && ofs_q == `FBP_OFS_DATA)
                data_q <= hwdata;
            if (wr && ofs_q == `FBP_OFS_IM)
                im_q <= hwdata[1:0];
            // set wins over clear
            ris_q[`FBP_IRQ_ACCESS] <= deny | (ris_q[`FBP_IRQ_ACCESS] &
                ~(wr && ofs_q == `FBP_OFS_MISC && hwdata[`FBP_IRQ_ACCESS]));
            ris_q[`FBP_IRQ_PROG] <= (fl_done & (busy_q != 4'h0) & ~busy_q[3]) |
                (ris_q[`FBP_IRQ_PROG] &
                ~(wr && ofs_q == `FBP_OFS_MISC && hwdata[`FBP_IRQ_PROG]));
            flt_q[0] <= rd_fault | (flt_q[0] &
                ~(wr && ofs_q == `FBP_OFS_FLT && hwdata[0]));
            flt_q[1] <= (rd_fault & rd_debug) | (flt_q[1] &
                ~(wr && ofs_q == `FBP_OFS_FLT && hwdata[1]));
        end
    end

    // ----------------------------------------
    // protection and debug words
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (por)
        begin
            // factory image only when both resets are held together
            // committed copies otherwise survive a power-on reset
            if (srst)
            begin
                rden_nv_q <= `FBP_PROT_RESET;
                pgen_nv_q <= `FBP_PROT_RESET;
                dbgw_nv_q <= `FBP_DBGW_RESET;
            end
            rden_q <= `FBP_PROT_RESET;
            pgen_q <= `FBP_PROT_RESET;
            dbgw_q <= `FBP_DBGW_RESET;
            dbg_en_q <= 1'b0;
            por_done_q <= 1'b0;
        end
        else
        begin
            por_done_q <= 1'b1;
            if (!por_done_q)
            begin
                // uncommitted bits revert on power-on
                rden_q <= rden_nv_q;
                pgen_q <= pgen_nv_q;
                dbgw_q <= dbgw_nv_q;
                dbg_en_q <= dbgw_nv_q[`FBP_DBG_HI] & ~dbgw_nv_q[`FBP_DBG_LO];
            end
            else
            begin
                if (wr && ofs_q == `FBP_OFS_RDEN)
                    rden_q <= rden_q & hwdata;
                if (wr && ofs_q == `FBP_OFS_PGEN)
                    pgen_q <= pgen_q & hwdata;
            end
            if (cm_cmd && addr_q == `FBP_SEL_RDEN)
                rden_nv_q <= rden_nv_q & rden_q;
            if (cm_cmd && addr_q == `FBP_SEL_PGEN)
                pgen_nv_q <= pgen_nv_q & pgen_q;
            if (cm_cmd && addr_q == `FBP_SEL_DBGW && dbgw_nv_q[31])
                dbgw_nv_q <= dbgw_nv_q & data_q & 32'h7FFFFFFF;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (srst)
            hrdata <= 32'h00000000;
        else if (take && !hwrite)
        begin
            case (haddr[11:0])
                `FBP_OFS_ADDR: hrdata <= addr_q;
                `FBP_OFS_DATA: hrdata <= data_q;
                `FBP_OFS_CTRL: hrdata <= {28'h0000000, busy_q};
                `FBP_OFS_RIS: hrdata <= {30'h0, ris_q};
                `FBP_OFS_IM: hrdata <= {30'h0, im_q};
                `FBP_OFS_MISC: hrdata <= {30'h0, ris_q & im_q};
                `FBP_OFS_RDEN: hrdata <= rden_q;
                `FBP_OFS_PGEN: hrdata <= pgen_q;
                `FBP_OFS_DBGW: hrdata <= dbgw_q;
                `FBP_OFS_FLT: hrdata <= {30'h0, flt_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: fbp_unit_properties.sv
// checker on the protection unit's ports
// assumes binding into fbp_unit, one clock, srst and por resets
`timescale 1ns/100ps
`default_nettype none
module fbp_unit_props (
    // clock and resets
    input wire clk,
    input wire srst,
    input wire por,
    // bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    // gates and array
    input wire rd_req,
    input wire rd_fetch,
    input wire rd_debug,
    input wire rd_allow,
    input wire rd_fault,
    input wire fl_start_q,
    input wire [2:0] fl_op_q,
    input wire fl_done,
    input wire dbg_req,
    input wire dbg_allow,
    input wire dbg_enabled,
    input wire irq
);
    logic dp_wr_q;
    // data phase of a bus write
    always_ff @(posedge clk)
        dp_wr_q <= !srst && hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || por);
    sequence s_pulse;
        $onehot(fl_op_q) ##1 !fl_start_q;
    endsequence
    fault_pair_a: assert property (rd_req |-> rd_fault == !rd_allow)
        else $error("read fault not inverse of allow");
    fetch_open_a: assert property (rd_req && rd_fetch && !rd_debug |-> rd_allow)
        else $error("instruction fetch refused");
    dbg_gate_a: assert property (dbg_allow == (dbg_req && dbg_enabled))
        else $error("debug gate wrong");
    dbg_read_a: assert property (rd_req && rd_debug && !dbg_enabled |-> rd_fault)
        else $error("debugger read while disabled");
    dbg_hold_a: assert property (!dbg_enabled && !$past(por) |=> !dbg_enabled)
        else $error("debug enabled again");
    start_pulse_a: assert property (fl_start_q |-> s_pulse)
        else $error("start not a one-hot pulse");
    irq_rise_a: assert property ($rose(irq) |->
        $past(dp_wr_q) || $past(dp_wr_q, 2) || $past(fl_done)) else $error("irq rose alone");
    irq_fall_a: assert property ($fell(irq) && !$past(srst) |-> $past(dp_wr_q))
        else $error("irq fell without a write");
endmodule
bind fbp_unit fbp_unit_props fbp_unit_props_inst (.*);
`default_nettype wire

// file: fbp_flash_model.sv
// flash array model: answers each start with a done pulse unless lat is 8'hFF, where lat + 1 wraps to zero
// assumes fl_start_q is a one-cycle pulse; lat sets the delay
`timescale 1ns/100ps
`default_nettype none
module fbp_flash_model (
    // clock
    input wire logic clk,
    // array port
    input wire logic fl_start_q,
    input wire logic [7:0] lat,
    output logic fl_done
);
    logic [7:0] cnt_q = 8'h00;
    initial fl_done = 1'h0;
    always @(posedge clk)
    begin
        fl_done <= cnt_q == 8'h01;
        if (fl_start_q)
            cnt_q <= lat + 8'h01;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
endmodule
`default_nettype wire

// file: fbp_unit_test.sv
// self-checking bench for the flash block protection unit
// assumes fbp_unit beside a flash array model on its program port
`timescale 1ns/100ps
`default_nettype none
`include "fbp_defs.vh"
module fbp_unit_test;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic por = 1'h1;
    logic hsel = 1'h0, hwrite = 1'h0, rd_req = 1'h0, rd_fetch = 1'h0, rd_debug = 1'h0;
    logic dbg_req = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fl_addr_q, fl_data_q, q, a, dv;
    logic [31:0] rd_exp, pg_exp;
    logic [15:0] rd_addr = 16'h0;
    logic [7:0] lat = 8'h0;
    logic [4:0] b, c, blk;
    logic [2:0] fl_op_q, op_seen;
    logic hreadyout, hresp, rd_allow, rd_fault, fl_start_q, fl_done, dbg_allow, dbg_enabled, irq;
    logic dbg_exp, started, al;
    wire hready = hreadyout;
    int miscompares = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    fbp_unit fbp_unit_inst (.*);
    fbp_flash_model fbp_flash_model_inst (.*);
    always @(posedge clk)
        if (fl_start_q)
        begin
            started <= 1'h1;
            op_seen <= fl_op_q;
        end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {20'h0, ad};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        q = hrdata;
        chk("response", hresp, 32'h0);
    endtask
    task automatic rchk(input string n, input logic [11:0] ad, input logic [31:0] e);
        bus(1'h0, ad, 32'h0);
        chk(n, q, e);
    endtask
    // address, keyed command, then poll busy bits
    task automatic op(input logic [31:0] ad, input logic [3:0] cmd);
        bus(1'h1, `FBP_OFS_ADDR, ad);
        bus(1'h1, `FBP_OFS_CTRL, {`FBP_KEY, 12'h0, cmd});
        for (int i = 0; i < 50 && (i == 0 || q[3:0] != 4'h0); i++)
            bus(1'h0, `FBP_OFS_CTRL, 32'h0);
    endtask
    task automatic pwr;
        @(posedge clk) por <= 1'h1;
        @(posedge clk) por <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic allow_f(input logic [15:0] ad, input logic f, input logic d);
        return (f && !d || rd_exp[ad[15:11]]) && (!d || dbg_exp);
    endfunction
    task automatic sweep;
        for (int i = 0; i < 24; i++)
        begin
            rd_req <= 1'h1;
            rd_fetch <= i[0];
            rd_debug <= i[1];
            dbg_req <= i[2];
            rd_addr <= i[2] ? {b, i[3] ? 11'h7FF : 11'h000} : 16'($urandom);
            @(negedge clk);
            chk("read allow", rd_allow, allow_f(rd_addr, rd_fetch, rd_debug));
            chk("read fault", rd_fault, !allow_f(rd_addr, rd_fetch, rd_debug));
            chk("debug allow", dbg_allow, dbg_req && dbg_exp);
            @(posedge clk);
        end
        rd_req <= 1'h0;
    endtask
    task automatic conclude;
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude;
    end
    initial
    begin
        void'($urandom(32'h98dc));
        rd_exp = 32'hFFFFFFFF;
        pg_exp = 32'hFFFFFFFF;
        dbg_exp = 1'h1;
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        por <= 1'h0;
        repeat (2) @(posedge clk);
        rchk("read enable", `FBP_OFS_RDEN, rd_exp);
        rchk("program enable", `FBP_OFS_PGEN, pg_exp);
        rchk("debug word", `FBP_OFS_DBGW, 32'hFFFFFFFE);
        rchk("unmapped", 12'h0FC, 32'h0);
        chk("debug on", dbg_enabled, 1'h1);
        b = 5'($urandom);
        c = b + 5'($urandom % 31) + 5'h1;
        rd_exp[b] = 1'h0;
        pg_exp[c] = 1'h0;
        bus(1'h1, `FBP_OFS_RDEN, ~(32'h1 << b));
        bus(1'h1, `FBP_OFS_RDEN, 32'hFFFFFFFF);
        bus(1'h1, `FBP_OFS_PGEN, ~(32'h1 << c));
        rchk("read enable", `FBP_OFS_RDEN, rd_exp);
        rchk("program enable", `FBP_OFS_PGEN, pg_exp);
        sweep;
        bus(1'h1, `FBP_OFS_IM, 32'h1);
        for (int k = 0; k < 6; k++)
        begin
            blk = k < 3 ? c : b;
            lat <= 8'($urandom % 6);
            started = 1'h0;
            a = {16'h0, blk, 11'($urandom)};
            dv = $urandom;
            bus(1'h1, `FBP_OFS_DATA, dv);
            op(a, 4'h1 << (k % 3));
            al = k % 3 == 2 ? &pg_exp : pg_exp[blk];
            chk("started", started, al);
            if (al)
            begin
                chk("operation", op_seen, 3'h1 << (k % 3));
                chk("flash address", fl_addr_q, a);
                chk("flash data", fl_data_q, dv);
            end
            rchk("raw status", `FBP_OFS_RIS, al ? 32'h2 : 32'h1);
            rchk("masked status", `FBP_OFS_MISC, {31'h0, !al});
            chk("irq", irq, !al);
            bus(1'h1, `FBP_OFS_MISC, 32'h3);
            rchk("raw cleared", `FBP_OFS_RIS, 32'h0);
        end
        op(`FBP_SEL_RDEN, 4'h8);
        pg_exp = 32'hFFFFFFFF;
        pwr;
        rchk("read enable", `FBP_OFS_RDEN, rd_exp);
        rchk("program enable", `FBP_OFS_PGEN, pg_exp);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'h1, `FBP_OFS_DATA, k ? 32'hFFFFFFFE : 32'h7FFFFFFC);
            op(`FBP_SEL_DBGW, 4'h8);
            pwr;
            chk("debug on", dbg_enabled, 1'h0);
        end
        dbg_exp = 1'h0;
        sweep;
        rchk("fault flags", `FBP_OFS_FLT, 32'h3);
        bus(1'h1, `FBP_OFS_FLT, 32'h3);
        rchk("fault cleared", `FBP_OFS_FLT, 32'h0);
        conclude;
    end
endmodule
`default_nettype wire
